// ===== common/pwr_seq_map.svh
// Register offsets, field positions, reset values and sizes of the power state control slice.
//
// Overview of operation
// RULE_01 - Writing one to the transport request bit sends the device to transport state.
// RULE_02 - Minimal-logic request set moves device to minimal-logic state once regulators are shut.
// RULE_03 - Each shutdown slot field resets to that regulator's fused power-up slot; code loads it one edge after reset, from test settings if TEST_SEL.
// RULE_04 - Power-down turns regulators off one at a time, highest slot first.
// RULE_05 - Host rewrites shutdown slots only while the device is in a system-on state.
// RULE_06 - All shutdown slots zero: skip ordering and turn every regulator off at once.
// RULE_07 - Power-up order comes only from fuses or test settings, never register writes.
// RULE_08 - Two-bit undervoltage select picks one of four threshold pairs, resets to 00.
// RULE_09 - Two-bit low-system warning select picks one of four pairs, resets to 00.
// RULE_10 - Unused upper bits read as zero and ignore writes.
`ifndef PWR_SEQ_MAP_SVH
`define PWR_SEQ_MAP_SVH

`define ADDR_SUPPLY_THRESHOLD_SELECT 8'h5A
`define ADDR_LOW_POWER_STATE_REQUEST 8'h5B
`define ADDR_SHUTDOWN_SLOT_BASE      8'h5F
`define NUM_REGULATORS               7
`define SLOT_W                       3
`define UV_SEL_LSB                   0
`define WARN_SEL_LSB                 2
`define TRANSPORT_BIT                0
`define MINIMAL_BIT                  1
`define UV_SEL_RESET                 2'h0
`define WARN_SEL_RESET               2'h0
`define SLOT_RESET                   3'h0
`define SLOT_TOP                     3'h7

`endif

// ===== common/pwr_seq_pkg.sv
// Types shared by the power state control slice.
package pwr_seq_pkg;

  typedef struct packed {
    logic       en;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_wr_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_STEP = 2'b01,
    SEQ_DONE = 2'b10
  } seq_state_t;

endpackage : pwr_seq_pkg

// ===== verilog/pwr_seq_ctrl.sv
// Threshold selects, low-power state requests and ordered regulator shutdown.
`timescale 1ns/10ps
`include "pwr_seq_map.svh"

module pwr_seq_ctrl #(
  parameter int N_REG = `NUM_REGULATORS
) (
  // Clock and reset.
  input  wire logic                     CLK_SYS,
  input  wire logic                     ARST_N,
  // Register port from the serial slave.
  input  wire pwr_seq_pkg::reg_wr_t     REG_WR,
  input  wire logic [7:0]               RD_ADDR,
  output logic [7:0]                    RD_DATA,
  // Fuse and test-setting power-up slots, packed per regulator.
  input  wire logic [N_REG*3-1:0]       FUSE_UP_SLOT,
  input  wire logic                     TEST_SEL,
  input  wire logic [N_REG*3-1:0]       TEST_UP_SLOT,
  // State machine status and commands.
  input  wire logic                     SYS_ON,
  input  wire logic                     REGS_SHUT,
  input  wire logic                     REGS_POWER_UP,
  input  wire logic                     PWRDN_START,
  output logic                          TRANSPORT_GO,
  output logic                          MINIMAL_GO,
  // Regulator controls and comparator selects.
  output logic [N_REG-1:0]              REG_EN,
  output logic                          PWRDN_BUSY,
  output logic [N_REG*3-1:0]            PWRUP_SLOT,
  output logic [1:0]                    UV_SEL,
  output logic [1:0]                    WARN_SEL
);

  ////////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [1:0]         uv_q, uv_d, warn_q, warn_d;
  logic [1:0]         req_q, req_d;
  logic [2:0]         slot_q [N_REG];
  logic [2:0]         slot_d [N_REG];
  logic [N_REG*3-1:0] up_q, up_d;
  logic               loaded_q, loaded_d;
  logic               tgo_q, tgo_d, mgo_q, mgo_d;
  logic [7:0]         rd_q, rd_d;
  logic [N_REG*3-1:0] fuse_src;

  // Slots reset to a constant and take the fuse or test-setting value on the first edge after release,
  // so an asynchronous reset never samples a port.
  assign fuse_src = TEST_SEL ? TEST_UP_SLOT : FUSE_UP_SLOT;

  always_comb begin
    uv_d     = uv_q;
    warn_d   = warn_q;
    req_d    = req_q;
    up_d     = up_q;
    loaded_d = 1'b1;
    tgo_d    = 1'b0;
    for (int i = 0; i < N_REG; i++) begin
      slot_d[i] = slot_q[i];
    end
    if (!loaded_q) begin
      up_d = fuse_src;                                         // see RULE_07
      for (int i = 0; i < N_REG; i++) begin
        slot_d[i] = fuse_src[i*3 +: 3];                        // see RULE_03
      end
    end else if (REG_WR.en) begin
      if (REG_WR.addr == `ADDR_SUPPLY_THRESHOLD_SELECT) begin
        uv_d   = REG_WR.data[`UV_SEL_LSB +: 2];                // see RULE_08
        warn_d = REG_WR.data[`WARN_SEL_LSB +: 2];              // see RULE_09
      end
      if (REG_WR.addr == `ADDR_LOW_POWER_STATE_REQUEST) begin
        req_d = REG_WR.data[1:0];                              // see RULE_10
        tgo_d = REG_WR.data[`TRANSPORT_BIT];                   // see RULE_01
      end
      for (int i = 0; i < N_REG; i++) begin
        if (SYS_ON && REG_WR.addr == 8'(`ADDR_SHUTDOWN_SLOT_BASE + i)) begin
          slot_d[i] = REG_WR.data[2:0];                        // see RULE_05
        end
      end
    end
    mgo_d = req_q[`MINIMAL_BIT] & REGS_SHUT & ~mgo_q;          // see RULE_02
    rd_d  = 8'h00;
    if (RD_ADDR == `ADDR_SUPPLY_THRESHOLD_SELECT) begin
      rd_d = {4'h0, warn_q, uv_q};                             // see RULE_10
    end else if (RD_ADDR == `ADDR_LOW_POWER_STATE_REQUEST) begin
      rd_d = {6'h00, req_q};
    end
    for (int i = 0; i < N_REG; i++) begin
      if (RD_ADDR == 8'(`ADDR_SHUTDOWN_SLOT_BASE + i)) begin
        rd_d = {5'h00, slot_q[i]};
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      uv_q     <= `UV_SEL_RESET;
      warn_q   <= `WARN_SEL_RESET;
      req_q    <= 2'h0;
      up_q     <= '0;
      loaded_q <= 1'b0;
      tgo_q    <= 1'b0;
      mgo_q    <= 1'b0;
      rd_q     <= 8'h00;
      for (int i = 0; i < N_REG; i++) begin
        slot_q[i] <= `SLOT_RESET;
      end
    end else begin
      uv_q     <= uv_d;
      warn_q   <= warn_d;
      req_q    <= req_d;
      up_q     <= up_d;
      loaded_q <= loaded_d;
      tgo_q    <= tgo_d;
      mgo_q    <= mgo_d;
      rd_q     <= rd_d;
      for (int i = 0; i < N_REG; i++) begin
        slot_q[i] <= slot_d[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power-down sequencer.

  pwr_seq_pkg::seq_state_t st_q, st_d;
  logic [2:0]              cur_q, cur_d;
  logic [N_REG-1:0]        en_q, en_d, hit, nz;
  logic [N_REG-1:0]        lowest;
  logic                    busy_q, busy_d;

  for (genvar g = 0; g < N_REG; g++) begin : g_match
    assign hit[g] = en_q[g] && (slot_q[g] == cur_q);
    assign nz[g]  = (slot_q[g] != `SLOT_RESET);
  end

  // Only the lowest matching regulator drops per cycle, so equal slots still go singly.
  assign lowest = hit & (~hit + N_REG'(1));

  always_comb begin
    st_d  = st_q;
    cur_d = cur_q;
    en_d  = en_q;
    unique case (st_q)
      pwr_seq_pkg::SEQ_IDLE: begin
        if (REGS_POWER_UP) begin
          en_d = '1;
        end else if (PWRDN_START) begin
          if (nz == '0) begin
            en_d = '0;                                         // see RULE_06
            st_d = pwr_seq_pkg::SEQ_DONE;
          end else begin
            cur_d = `SLOT_TOP;
            st_d  = pwr_seq_pkg::SEQ_STEP;
          end
        end
      end
      pwr_seq_pkg::SEQ_STEP: begin
        if (hit != '0) begin
          en_d = en_q & ~lowest;                               // see RULE_04
        end else if (cur_q == `SLOT_RESET) begin
          st_d = pwr_seq_pkg::SEQ_DONE;
        end else begin
          cur_d = cur_q - 3'h1;                                // see RULE_04
        end
      end
      pwr_seq_pkg::SEQ_DONE: begin
        st_d = pwr_seq_pkg::SEQ_IDLE;
      end
      default: begin
        st_d = pwr_seq_pkg::SEQ_IDLE;
      end
    endcase
    // Busy is registered from the next state so the port comes straight from a flop.
    busy_d = (st_d != pwr_seq_pkg::SEQ_IDLE);
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q   <= pwr_seq_pkg::SEQ_IDLE;
      cur_q  <= `SLOT_RESET;
      en_q   <= '0;
      busy_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      cur_q  <= cur_d;
      en_q   <= en_d;
      busy_q <= busy_d;
    end
  end

  assign RD_DATA      = rd_q;
  assign TRANSPORT_GO = tgo_q;
  assign MINIMAL_GO   = mgo_q;
  assign REG_EN       = en_q;
  assign PWRDN_BUSY   = busy_q;
  assign PWRUP_SLOT   = up_q;
  assign UV_SEL       = uv_q;
  assign WARN_SEL     = warn_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  a_transport_pulse: assert property (loaded_q && REG_WR.en && // see RULE_01
    REG_WR.addr == `ADDR_LOW_POWER_STATE_REQUEST && REG_WR.data[0] |=> TRANSPORT_GO)
    else $error("transport request not issued");
  a_transport_zero: assert property (TRANSPORT_GO |-> $past(REG_WR.en) && // see RULE_01
    $past(REG_WR.addr) == `ADDR_LOW_POWER_STATE_REQUEST && $past(REG_WR.data[0]))
    else $error("transport issued without a written one");
  a_minimal_cause: assert property ($rose(MINIMAL_GO) |-> // see RULE_02
    $past(REGS_SHUT) && $past(req_q[1])) else $error("minimal-logic without cause");
  a_slot_load: assert property ($rose(loaded_q) |-> // see RULE_03
    slot_q[0] == $past(fuse_src[2:0])) else $error("slot not loaded from fuse");
  a_one_at_time: assert property (st_q == pwr_seq_pkg::SEQ_STEP |=> // see RULE_04
    $countones($past(en_q) & ~en_q) <= 1) else $error("two regulators dropped at once");
  a_slot_guard: assert property (loaded_q && !SYS_ON |=> // see RULE_05
    slot_q[0] == $past(slot_q[0])) else $error("slot changed outside system-on");
  a_bypass_all: assert property (st_q == pwr_seq_pkg::SEQ_IDLE && !REGS_POWER_UP && // see RULE_06
    PWRDN_START && nz == '0 |=> REG_EN == '0) else $error("bypass did not drop all");
  a_upslot_fixed: assert property (loaded_q && $past(loaded_q) |-> $stable(up_q)) // see RULE_07
    else $error("power-up order changed");
  a_uv_reset: assert property ($rose(loaded_q) |-> UV_SEL == 2'h0 && WARN_SEL == 2'h0) // see RULE_08
    else $error("threshold selects not reset");
  a_read_zeros: assert property (RD_ADDR == `ADDR_SUPPLY_THRESHOLD_SELECT |=> // see RULE_10
    RD_DATA[7:4] == 4'h0 && RD_DATA[3:2] == $past(warn_q)) else $error("upper bits nonzero");

endmodule : pwr_seq_ctrl

// ===== verification/host_model.sv
// Host processor model driving the register port behind the serial slave.
`timescale 1ns/10ps
module host_model (
  // Clock and state.
  input  wire logic            CLK_SYS,
  input  wire logic            SYS_ON,
  // Register port.
  output pwr_seq_pkg::reg_wr_t REG_WR,
  output logic [7:0]           RD_ADDR,
  input  wire logic [7:0]      RD_DATA
);
  initial begin
    REG_WR = '0;
    RD_ADDR = 8'h00;
  end
  // A careful host leaves slot fields alone outside system-on; rogue is for refusal tests.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit rogue = 1'b0);
    // State is looked at after an edge, so a mode change made just before the call is seen.
    @(posedge CLK_SYS);
    if (a < 8'h5F || SYS_ON || rogue) begin
      REG_WR <= '{en: 1'b1, addr: a, data: d};
      @(posedge CLK_SYS) REG_WR.en <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge CLK_SYS) RD_ADDR <= a;
    @(posedge CLK_SYS);
    #1 d = RD_DATA;
  endtask : rd
endmodule : host_model

// ===== verification/tb.sv
// Self-checking bench for the power state control slice.
`timescale 1ns/10ps
module tb;
  localparam logic [20:0] FUSE = {3'h5, 3'h2, 3'h6, 3'h3, 3'h7, 3'h4, 3'h1};
  localparam logic [20:0] TEST = 21'h0AAAAA;
  logic clk = 1'b0, arst_n = 1'b0, test_sel = 1'b1, sys_on = 1'b1, shut = 1'b0;
  logic up = 1'b0, go = 1'b0, tgo, mgo, busy;
  pwr_seq_pkg::reg_wr_t reg_wr;
  logic [7:0] rd_addr, rd_data, d;
  logic [6:0] en;
  logic [20:0] upslot;
  logic [1:0] uv, warn;
  logic [2:0] slot [7];
  int errors = 0, cmp_count = 0, n;
  always #2.5 clk = ~clk;
  pwr_seq_ctrl i_dut (.CLK_SYS(clk), .ARST_N(arst_n), .REG_WR(reg_wr), .RD_ADDR(rd_addr),
    .RD_DATA(rd_data), .FUSE_UP_SLOT(FUSE), .TEST_SEL(test_sel), .TEST_UP_SLOT(TEST),
    .SYS_ON(sys_on), .REGS_SHUT(shut), .REGS_POWER_UP(up), .PWRDN_START(go),
    .TRANSPORT_GO(tgo), .MINIMAL_GO(mgo), .REG_EN(en), .PWRDN_BUSY(busy),
    .PWRUP_SLOT(upslot), .UV_SEL(uv), .WARN_SEL(warn));
  host_model i_host (.CLK_SYS(clk), .SYS_ON(sys_on), .REG_WR(reg_wr), .RD_ADDR(rd_addr),
    .RD_DATA(rd_data));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [20:0] seen, input logic [20:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : tally_and_finish
  task automatic reset_dut();
    @(posedge clk) arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
  endtask : reset_dut
  task automatic pulses(input bit minimal, output int h);
    h = 0;
    repeat (6) begin
      #1 h += minimal ? mgo : tgo;
      @(posedge clk);
    end
  endtask : pulses
  // Highest slot first, lowest index on a tie; all zero means everything at once.
  function automatic logic [6:0] pick(input logic [6:0] e);
    logic [6:0] m;
    int best;
    logic [2:0] z;
    m = '0;
    best = -1;
    z = '0;
    for (int i = 0; i < 7; i++) z |= slot[i];
    if (z == 3'h0) return e;
    for (int i = 0; i < 7; i++) if (e[i] && int'(slot[i]) > best) begin
      best = int'(slot[i]);
      m = 7'h01 << i;
    end
    return m;
  endfunction : pick
  task automatic pd();
    logic [6:0] prev;
    @(posedge clk) up <= 1'b1;
    @(posedge clk) up <= 1'b0;
    @(posedge clk) go <= 1'b1;
    #1 chk("reg_en_up", en, 7'h7F);
    @(posedge clk) go <= 1'b0;
    #1 chk("busy_on", busy, 1'b1);
    prev = 7'h7F;
    for (int k = 0; k < 30 && (busy !== 1'b0 || en !== 7'h00); k++) begin
      @(posedge clk);
      #1 if (en !== prev) begin
        chk("reg_en_step", en, prev & ~pick(prev));
        prev = en;
      end
    end
    chk("reg_en_off", en, 7'h00);
    chk("busy_off", busy, 1'b0);
    if (en !== 7'h00 || busy !== 1'b0) tally_and_finish();
  endtask : pd
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_dut();
    chk("reset_outs", {en, busy, tgo, mgo}, 21'h0);
    chk("pwrup_test", upslot, TEST);
    test_sel <= 1'b0;
    reset_dut();
    chk("pwrup_fuse", upslot, FUSE);
    for (int i = 0; i < 7; i++) begin
      slot[i] = FUSE[3*i+:3];
      i_host.rd(8'(8'h5F + i), d);
      chk("slot_reset", d, slot[i]);
    end
    i_host.rd(8'h5A, d);
    chk("thr_reset", {d, uv, warn}, 21'h0);
    i_host.rd(8'h70, d);
    chk("unmapped", d, 21'h0);
    for (int k = 0; k < 4; k++) begin
      i_host.wr(8'h5A, 8'(8'hF0 + 5 * k));
      i_host.rd(8'h5A, d);
      chk("thr_sel", {d, uv, warn}, {8'(5 * k), 2'(k), 2'(k)});
    end
    // Unequal codes tell the two fields apart.
    i_host.wr(8'h5A, 8'h06);
    i_host.rd(8'h5A, d);
    chk("thr_order", {d, uv, warn}, {8'h06, 2'h2, 2'h1});
    i_host.wr(8'h5B, 8'h01);
    pulses(1'b0, n);
    chk("transport_one", 21'(n), 21'h1);
    i_host.wr(8'h5B, 8'h00);
    pulses(1'b0, n);
    chk("transport_zero", 21'(n), 21'h0);
    // Minimal-logic request must wait until the regulators are shut.
    i_host.wr(8'h5B, 8'h02);
    i_host.rd(8'h5B, d);
    chk("req_read", d, 8'h02);
    pulses(1'b1, n);
    chk("minimal_early", 21'(n), 21'h0);
    @(posedge clk) shut <= 1'b1;
    pulses(1'b1, n);
    chk("minimal_shut", 21'(n > 0), 21'h1);
    i_host.wr(8'h5B, 8'h00);
    @(posedge clk) shut <= 1'b0;
    pd();
    @(posedge clk) sys_on <= 1'b0;
    i_host.wr(8'h60, 8'h01, 1'b1);
    i_host.rd(8'h60, d);
    chk("slot_locked", d, slot[1]);
    @(posedge clk) sys_on <= 1'b1;
    i_host.wr(8'h5F, 8'hFF);
    slot[0] = 3'h7;
    i_host.rd(8'h5F, d);
    chk("slot_new", d, 8'h07);
    chk("pwrup_kept", upslot, FUSE);
    pd();
    for (int i = 0; i < 7; i++) begin
      i_host.wr(8'(8'h5F + i), 8'h00);
      slot[i] = 3'h0;
    end
    pd();
    tally_and_finish();
  end
endmodule : tb
